//--- logic/adc_cycle_pkg.sv
// constants shared by both ends of the converter select/busy/serial-readout link
// assumes a single 25 MHz system clock on each end; link pins cross into it by two flip-flops
//
// Contract
// R1: normal mode: select high at least 150 ns
// R2: busy rises within 100/30 ns, gain/bypass; code: bypass delay is held at one 40 ns cycle, gain delay is 2 cycles (80 ns)
// R3: gain enabled: conversion done in 1550 ns
// R4: gain bypassed: conversion done in 660 ns
// R5: host gives 14 rising clocks after busy falls
// R6: last falling clock may meet next select rise
// R7: serial clock no faster than 50 MHz
// R8: six more clocks read six trailer bits
// R9: trailer: channel bits first, then gain, msb first
// R10: trailer readable in any mode; lengthen period
// R11: normal periods 1.11, 2.07, 2.19 us minimum
// R12: normal, bypass, channel bits only: 1.17 us
// R13: low power: acquisition equals select high length
// R14: low power: select high at least 500 ns
// R15: low power: prefer minimum 500 ns select high
// R16: low power: first sample after power-up valid
// R17: low power periods 1.46, 2.42, 2.54 us minimum
// R18: low power, bypass, channel bits only: 1.52 us
// R19: select fall samples, converts, drives data low
// R20: busy high during conversion; msb then shifts
// R21: host holds serial clock low while busy
// R22: fewer trailer clocks give fewer trailer bits
// R23: host derives timing from mode, gain, trailer
package adc_cycle_pkg;

  localparam int CLK_PERIOD_NS = 40;

  localparam int DATA_BITS    = 14;
  localparam int SEL_BITS     = 3;
  localparam int TRAILER_BITS = 2 * SEL_BITS;
  localparam int WORD_BITS    = DATA_BITS + TRAILER_BITS;

  // least times round up, longest times round down, never below one cycle
  function automatic int ceil_cyc(input int t_ns);
    return (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  function automatic int floor_cyc(input int t_ns);
    return (t_ns / CLK_PERIOD_NS < 1) ? 1 : t_ns / CLK_PERIOD_NS;
  endfunction

  localparam int SELECT_HIGH_TIME_NORMAL_NS = 150;
  localparam int SELECT_HIGH_TIME_LOWPWR_NS = 500;
  localparam int BUSY_RISE_DELAY_GAIN_NS    = 100;
  localparam int BUSY_RISE_DELAY_BYPASS_NS  = 30;
  localparam int CONVERSION_TIME_GAIN_NS    = 1550;
  localparam int CONVERSION_TIME_BYPASS_NS  = 660;
  localparam int SCK_HALF_NS                = 160;
  localparam int SCK_MIN_PERIOD_NS          = 20;

  localparam int CSH_NORMAL_CYC = ceil_cyc(SELECT_HIGH_TIME_NORMAL_NS);
  localparam int CSH_LOWPWR_CYC = ceil_cyc(SELECT_HIGH_TIME_LOWPWR_NS);
  localparam int BUSY_GAIN_CYC  = floor_cyc(BUSY_RISE_DELAY_GAIN_NS);
  localparam int BUSY_BYP_CYC   = floor_cyc(BUSY_RISE_DELAY_BYPASS_NS);
  localparam int CONV_GAIN_CYC  = floor_cyc(CONVERSION_TIME_GAIN_NS);
  localparam int CONV_BYP_CYC   = floor_cyc(CONVERSION_TIME_BYPASS_NS);
  localparam int SCK_HALF_CYC   = ceil_cyc(SCK_HALF_NS);

  // minimum cycle_period per mode / gain / trailer length
  localparam int PER_N_BYP_NS     = 1110;
  localparam int PER_N_BYP_CH_NS  = 1170;
  localparam int PER_N_GAIN_NS    = 2070;
  localparam int PER_N_GAIN_ALLNS = 2190;
  localparam int PER_L_BYP_NS     = 1460;
  localparam int PER_L_BYP_CH_NS  = 1520;
  localparam int PER_L_GAIN_NS    = 2420;
  localparam int PER_L_GAIN_ALLNS = 2540;

  localparam int PER_N_BYP_CYC     = ceil_cyc(PER_N_BYP_NS);
  localparam int PER_N_BYP_CH_CYC  = ceil_cyc(PER_N_BYP_CH_NS);
  localparam int PER_N_GAIN_CYC    = ceil_cyc(PER_N_GAIN_NS);
  localparam int PER_N_GAIN_AL_CYC = ceil_cyc(PER_N_GAIN_ALLNS);
  localparam int PER_L_BYP_CYC     = ceil_cyc(PER_L_BYP_NS);
  localparam int PER_L_BYP_CH_CYC  = ceil_cyc(PER_L_BYP_CH_NS);
  localparam int PER_L_GAIN_CYC    = ceil_cyc(PER_L_GAIN_NS);
  localparam int PER_L_GAIN_AL_CYC = ceil_cyc(PER_L_GAIN_ALLNS);

  localparam logic [6:0] PERIOD_SAT = 7'h7f;
  localparam logic [5:0] CNT_RESET  = 6'h00;

endpackage

//--- logic/adc_link_if.sv
// the select / serial-clock / busy / serial-data link between host and converter
// the data line idles high when the converter does not drive it (weak pull-up)
`timescale 1ns/1ps
interface adc_link_if;
  logic cs_n;
  logic sck;
  logic busy;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport device (
    input  cs_n,
    input  sck,
    output busy,
    output sdo,
    output sdo_oe
  );

  modport host (
    output cs_n,
    output sck,
    input  busy,
    input  sdo_line
  );
endinterface

//--- logic/pin_sync.sv
// two flip-flop synchroniser for levels arriving from outside the clock domain
// assumes each bit is a slow level; no bus coherence between bits
`timescale 1ns/1ps
module pin_sync #(
  parameter int         WIDTH = 1,
  parameter logic [7:0] INIT  = 8'h00
) (
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= INIT[WIDTH-1:0];
      sync_o   <= INIT[WIDTH-1:0];
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule

//--- logic/adc_device.sv
// converter end: select fall starts a timed conversion, busy marks it, serial clock reads out
// assumes the host keeps its own timing rules; sample_i is a same-clock stand-in for the result
`timescale 1ns/1ps
module adc_device (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  adc_link_if.device       link,
  input  wire logic [13:0] sample_i,
  input  wire logic [2:0]  channel_select_bits_i,
  input  wire logic [2:0]  gain_select_bits_i,
  input  wire logic        low_power_select_i,
  input  wire logic        gain_bypass_i,
  output logic             conv_done_o,
  output logic             sample_valid_o,
  output logic [15:0]      acquisition_cycles_o
);
  typedef enum logic [3:0] {
    D_IDLE  = 4'b0001,
    D_DELAY = 4'b0010,
    D_CONV  = 4'b0100,
    D_READ  = 4'b1000
  } dev_state_e;

  localparam int WB = adc_cycle_pkg::WORD_BITS;

  dev_state_e    state_reg;
  logic          cs_s, sck_s, cs_d_reg, sck_d_reg;
  logic [5:0]    cnt_reg;
  logic [WB-1:0] word_reg, shift_reg;
  logic          busy_reg, sdo_reg, oe_reg, warm_reg;
  logic [15:0]   acq_cnt_reg;
  logic          cs_fall, cs_rise, sck_rise, conv_end;

  pin_sync #(.WIDTH(2), .INIT(8'h03)) u_sync (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .async_i  ({link.cs_n, link.sck}),
    .sync_o   ({cs_s, sck_s})
  );

  assign cs_fall  = cs_d_reg & ~cs_s;
  assign cs_rise  = ~cs_d_reg & cs_s;
  assign sck_rise = ~sck_d_reg & sck_s;
  assign conv_end = (state_reg == D_CONV) && (cnt_reg == adc_cycle_pkg::CNT_RESET);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_d_reg  <= 1'b1;
      sck_d_reg <= 1'b1;
    end else begin
      cs_d_reg  <= cs_s;
      sck_d_reg <= sck_s;
    end
  end

  // conversion sequencing; a select rise always aborts back to acquisition
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= D_IDLE;
      cnt_reg   <= adc_cycle_pkg::CNT_RESET;
    end else if (cs_rise) begin
      state_reg <= D_IDLE;
    end else begin
      unique case (state_reg)
        D_IDLE: begin
          if (cs_fall) begin
            state_reg <= D_DELAY;
            cnt_reg   <= gain_bypass_i ? 6'(adc_cycle_pkg::BUSY_BYP_CYC - 1)
                                       : 6'(adc_cycle_pkg::BUSY_GAIN_CYC - 1); // [R2]
          end
        end
        D_DELAY: begin
          if (cnt_reg == adc_cycle_pkg::CNT_RESET) begin
            state_reg <= D_CONV;
            cnt_reg   <= gain_bypass_i ? 6'(adc_cycle_pkg::CONV_BYP_CYC - 1)   // [R4]
                                       : 6'(adc_cycle_pkg::CONV_GAIN_CYC - 1); // [R3]
          end else begin
            cnt_reg <= cnt_reg - 6'h01;
          end
        end
        D_CONV: begin
          if (conv_end) begin
            state_reg <= D_READ;
          end else begin
            cnt_reg <= cnt_reg - 6'h01;
          end
        end
        D_READ: state_reg <= D_READ;
      endcase
    end
  end

  // busy covers exactly the conversion interval
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_reg <= 1'b0;
    end else if (cs_rise || conv_end) begin
      busy_reg <= 1'b0; // [R20]
    end else if (state_reg == D_DELAY && cnt_reg == adc_cycle_pkg::CNT_RESET) begin
      busy_reg <= 1'b1; // [R2] [R20]
    end
  end

  // sample instant: result and selections frozen at select fall
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_reg <= '0;
    end else if (cs_fall && state_reg == D_IDLE) begin
      word_reg <= {sample_i, channel_select_bits_i, gain_select_bits_i}; // [R19] [R9]
    end
  end

  // data line: released while select high, low from the fall, msb at busy fall
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_reg    <= 1'b0;
      sdo_reg   <= 1'b0;
      shift_reg <= '0;
    end else if (cs_rise) begin
      oe_reg  <= 1'b0; // [R19]
      sdo_reg <= 1'b0;
    end else if (cs_fall) begin
      oe_reg  <= 1'b1; // [R19]
      sdo_reg <= 1'b0;
    end else if (conv_end) begin
      sdo_reg   <= word_reg[WB-1];             // [R20]
      shift_reg <= {word_reg[WB-2:0], 1'b0};
    end else if (state_reg == D_READ && sck_rise) begin
      // one bit per rising edge, so a short trailer simply stops early
      sdo_reg   <= shift_reg[WB-1];            // [R20] [R8] [R9] [R22]
      shift_reg <= {shift_reg[WB-2:0], 1'b0};
    end
  end

  // acquisition length is the select high time itself
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acq_cnt_reg          <= 16'h0000;
      acquisition_cycles_o <= 16'h0000;
    end else if (cs_fall) begin
      acquisition_cycles_o <= acq_cnt_reg; // [R13]
      acq_cnt_reg          <= 16'h0000;
    end else if (cs_s && acq_cnt_reg != 16'hffff) begin
      acq_cnt_reg <= acq_cnt_reg + 16'h0001; // [R13]
    end
  end

  // normal mode needs one select pulse to wake internal circuitry
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      warm_reg       <= 1'b0;
      sample_valid_o <= 1'b0;
      conv_done_o    <= 1'b0;
    end else begin
      conv_done_o <= conv_end;
      if (conv_end) begin
        warm_reg       <= 1'b1;
        sample_valid_o <= low_power_select_i | warm_reg; // [R16]
      end
    end
  end

  assign link.busy   = busy_reg;
  assign link.sdo    = sdo_reg;
  assign link.sdo_oe = oe_reg;
endmodule

//--- logic/adc_host.sv
// host end: makes select and the serial clock, waits on busy, reads 14 data and 0..6 trailer bits
// assumes busy and data come from the converter's pins and are synchronised here
`timescale 1ns/1ps
module adc_host (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  adc_link_if.host         link,
  input  wire logic        start_i,
  input  wire logic        low_power_select_i,
  input  wire logic        gain_bypass_i,
  input  wire logic [2:0]  trailer_count_i,
  output logic             ready_o,
  output logic [13:0]      result_o,
  output logic [2:0]       channel_o,
  output logic [2:0]       gain_o,
  output logic             result_valid_o
);
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_HIGH = 5'b00010,
    H_WAIT = 5'b00100,
    H_CONV = 5'b01000,
    H_READ = 5'b10000
  } host_state_e;

  localparam int WB   = adc_cycle_pkg::WORD_BITS;
  localparam int HALF = adc_cycle_pkg::SCK_HALF_CYC;

  host_state_e   state_reg;
  logic          busy_s, sdo_s;
  logic          cs_n_reg, sck_reg;
  logic          lp_reg, byp_reg;
  logic [2:0]    trl_reg;
  logic [5:0]    cnt_reg;
  logic [6:0]    period_reg;
  logic [3:0]    phase_reg;
  logic [4:0]    bits_left_reg;
  logic [WB-1:0] data_reg;
  logic          done;
  logic          high_ok;
  logic [5:0]    trailer_aligned;

  // minimum cycle_period for the latched settings, in clock cycles
  function automatic logic [6:0] min_period(input logic lp, input logic byp,
                                            input logic [2:0] trl);
    logic [6:0] p;
    p = 7'h00;
    if (!lp) begin
      if (byp) begin
        p = (trl == 3'h0) ? 7'(adc_cycle_pkg::PER_N_BYP_CYC)         // [R11]
                          : (trl <= 3'h3) ? 7'(adc_cycle_pkg::PER_N_BYP_CH_CYC) // [R12]
                          : 7'(adc_cycle_pkg::PER_N_GAIN_AL_CYC);
      end else begin
        p = (trl == 3'h0) ? 7'(adc_cycle_pkg::PER_N_GAIN_CYC)
                          : 7'(adc_cycle_pkg::PER_N_GAIN_AL_CYC);   // [R11]
      end
    end else begin
      if (byp) begin
        p = (trl == 3'h0) ? 7'(adc_cycle_pkg::PER_L_BYP_CYC)         // [R17]
                          : (trl <= 3'h3) ? 7'(adc_cycle_pkg::PER_L_BYP_CH_CYC) // [R18]
                          : 7'(adc_cycle_pkg::PER_L_GAIN_AL_CYC);
      end else begin
        p = (trl == 3'h0) ? 7'(adc_cycle_pkg::PER_L_GAIN_CYC)
                          : 7'(adc_cycle_pkg::PER_L_GAIN_AL_CYC);   // [R17]
      end
    end
    return p;
  endfunction

  pin_sync #(.WIDTH(2), .INIT(8'h01)) u_sync (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .async_i  ({link.busy, link.sdo_line}),
    .sync_o   ({busy_s, sdo_s})
  );

  // select high time: 500 ns floor in low power, 150 ns otherwise
  assign high_ok = lp_reg ? (cnt_reg >= 6'(adc_cycle_pkg::CSH_LOWPWR_CYC - 1))   // [R14] [R15]
                          : (cnt_reg >= 6'(adc_cycle_pkg::CSH_NORMAL_CYC - 1));  // [R1]
  assign done    = (state_reg == H_READ) && (phase_reg == 4'(2 * HALF - 1))
                   && (bits_left_reg == 5'h01);
  assign trailer_aligned = data_reg[5:0] << (3'h6 - trl_reg);

  // settings are latched per sample so one sample's timing stays coherent
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lp_reg  <= 1'b0;
      byp_reg <= 1'b0;
      trl_reg <= 3'h0;
    end else if (state_reg == H_IDLE && start_i) begin
      lp_reg  <= low_power_select_i;                                  // [R23]
      byp_reg <= gain_bypass_i;                                       // [R23]
      trl_reg <= (trailer_count_i > 3'h6) ? 3'h6 : trailer_count_i;   // [R10] [R23]
    end
  end

  // cycles since the last select fall, saturating
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      period_reg <= adc_cycle_pkg::PERIOD_SAT;
    end else if (state_reg == H_HIGH && high_ok
                 && period_reg >= min_period(lp_reg, byp_reg, trl_reg)) begin
      period_reg <= 7'h01;
    end else if (period_reg != adc_cycle_pkg::PERIOD_SAT) begin
      period_reg <= period_reg + 7'h01;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg     <= H_IDLE;
      cnt_reg       <= adc_cycle_pkg::CNT_RESET;
      phase_reg     <= 4'h0;
      bits_left_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        H_IDLE: begin
          if (start_i) begin
            state_reg <= H_HIGH;
            cnt_reg   <= adc_cycle_pkg::CNT_RESET;
          end
        end
        H_HIGH: begin
          if (high_ok && period_reg >= min_period(lp_reg, byp_reg, trl_reg)) begin
            state_reg <= H_WAIT; // [R1] [R14] [R11] [R17]
          end else if (cnt_reg != 6'h3f) begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        H_WAIT: begin
          if (busy_s) begin
            state_reg <= H_CONV;
          end
        end
        H_CONV: begin
          if (!busy_s) begin
            state_reg     <= H_READ;
            phase_reg     <= 4'h0;
            bits_left_reg <= 5'(adc_cycle_pkg::DATA_BITS) + {2'b00, trl_reg}; // [R5] [R8]
          end
        end
        H_READ: begin
          if (phase_reg == 4'(2 * HALF - 1)) begin
            phase_reg     <= 4'h0;
            bits_left_reg <= bits_left_reg - 5'h01;
            if (bits_left_reg == 5'h01) begin
              state_reg <= H_IDLE;
            end
          end else begin
            phase_reg <= phase_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // serial clock is held low through conversion and driven only in readout
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sck_reg <= 1'b0;
    end else if (state_reg == H_READ && phase_reg == 4'(HALF - 1)) begin
      sck_reg <= 1'b1; // [R7]
    end else if (state_reg != H_READ || phase_reg == 4'(2 * HALF - 1)) begin
      sck_reg <= 1'b0; // [R21]
    end
  end

  // select: falls after the high time, rises on the last falling clock edge
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_n_reg <= 1'b1;
    end else if (state_reg == H_HIGH && high_ok
                 && period_reg >= min_period(lp_reg, byp_reg, trl_reg)) begin
      cs_n_reg <= 1'b0;
    end else if (done) begin
      cs_n_reg <= 1'b1; // [R6] [R8]
    end
  end

  // bits are taken at the end of each low half, just before the rising edge
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_reg <= '0;
    end else if (state_reg == H_CONV) begin
      data_reg <= '0;
    end else if (state_reg == H_READ && phase_reg == 4'(HALF - 1)) begin
      data_reg <= {data_reg[WB-2:0], sdo_s}; // [R5] [R8]
    end
  end

  // unread trailer bits report as zero
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_o       <= 14'h0000;
      channel_o      <= 3'h0;
      gain_o         <= 3'h0;
      result_valid_o <= 1'b0;
      ready_o        <= 1'b0;
    end else begin
      result_valid_o <= done;
      ready_o        <= (state_reg == H_IDLE) && !start_i;
      if (done) begin
        result_o  <= data_reg[trl_reg +: 14];
        channel_o <= trailer_aligned[5:3]; // [R9]
        gain_o    <= trailer_aligned[2:0]; // [R9]
      end
    end
  end

  assign link.cs_n = cs_n_reg;
  assign link.sck  = sck_reg;
endmodule

//--- verification/adc_cycle_chk.sv
// concurrent checks on the select / serial-clock / busy / data link
// assumes both ends run on the one 25 MHz clock given here
`timescale 1ns/1ps
module adc_cycle_chk (
  input  wire logic clock_i,
  input  wire logic arst_n_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic busy_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  input  wire logic sdo_line_i
);
  logic [5:0] high_cnt_reg;
  logic [4:0] rise_cnt_reg;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // saturates so a long idle never wraps into a short one
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) high_cnt_reg <= 6'h00;
    else if (!cs_n_i) high_cnt_reg <= 6'h00;
    else if (high_cnt_reg != 6'h3f) high_cnt_reg <= high_cnt_reg + 6'h01;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) rise_cnt_reg <= 5'h00;
    else if (cs_n_i) rise_cnt_reg <= 5'h00;
    else if ($rose(sck_i)) rise_cnt_reg <= rise_cnt_reg + 5'h01;
  end

  sequence select_taken;
    ##[1:5] (sdo_oe_i && !sdo_i) ##[1:3] busy_i;
  endsequence

  sequence sck_high_run;
    sck_i [*4] ##1 !sck_i;
  endsequence

  // at most 38 cycles high, so even the gain case ends inside 1550 ns
  chk_select_start: assert property ($fell(cs_n_i) |-> select_taken)
    else $error("select fall not followed by driven low data and busy");
  chk_conv_bound: assert property ($rose(busy_i) |-> busy_i [*8] ##[9:31] !busy_i)
    else $error("busy length outside conversion bounds");
  chk_sck_quiet: assert property (busy_i |-> !sck_i)
    else $error("serial clock high during conversion");
  chk_msb_driven: assert property ($fell(busy_i) |-> sdo_oe_i)
    else $error("data not driven when busy falls");
  chk_oe_release: assert property ($rose(cs_n_i) |-> ##[1:4] (!sdo_oe_i && sdo_line_i))
    else $error("data line not released after select rise");
  chk_csh_min: assert property ($fell(cs_n_i) |-> high_cnt_reg >= 6'h04)
    else $error("select high time too short");
  chk_rise_count: assert property ($rose(cs_n_i) |-> rise_cnt_reg inside {[14:20]})
    else $error("serial clock rise count out of range");
  chk_sck_width: assert property ($rose(sck_i) |-> sck_high_run)
    else $error("serial clock high phase wrong length");
  chk_last_edge: assert property ($rose(cs_n_i) |-> $fell(sck_i))
    else $error("select rise not on last falling clock");

  cover property ($rose(cs_n_i) && rise_cnt_reg == 5'h14);
endmodule

//--- verification/sar_adc_conversion_readout_cycle_bench.sv
// self-checking bench: host and converter ends joined by the link interface
// assumes the design files under logic/ are compiled first
`timescale 1ns/1ps
module sar_adc_conversion_readout_cycle_bench;
  typedef struct packed {
    logic [13:0] data;
    logic [2:0]  ch;
    logic [2:0]  gain;
    logic        valid;
  } note_s;

  logic        clock_i;
  logic        arst_n_i;
  logic        start_i;
  logic        low_power_select_i;
  logic        gain_bypass_i;
  logic [2:0]  trailer_count_i;
  logic [13:0] sample_i;
  logic [2:0]  channel_select_bits_i;
  logic [2:0]  gain_select_bits_i;
  logic        ready_o;
  logic        result_valid_o;
  logic        conv_done_o;
  logic        sample_valid_o;
  logic [13:0] result_o;
  logic [2:0]  channel_o;
  logic [2:0]  gain_o;
  logic [15:0] acquisition_cycles_o;
  int          err_total;
  int          n_tests;
  int          seed;
  int          m;
  logic        prior_done;
  note_s       notes[$];
  note_s       got;
  logic [2:0]  trl [5] = '{3'h0, 3'h1, 3'h3, 3'h6, 3'h7};

  adc_link_if link();

  adc_device adc_device_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .link(link),
    .sample_i(sample_i), .channel_select_bits_i(channel_select_bits_i),
    .gain_select_bits_i(gain_select_bits_i), .low_power_select_i(low_power_select_i),
    .gain_bypass_i(gain_bypass_i), .conv_done_o(conv_done_o),
    .sample_valid_o(sample_valid_o), .acquisition_cycles_o(acquisition_cycles_o));

  adc_host adc_host_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .link(link),
    .start_i(start_i), .low_power_select_i(low_power_select_i),
    .gain_bypass_i(gain_bypass_i), .trailer_count_i(trailer_count_i), .ready_o(ready_o),
    .result_o(result_o), .channel_o(channel_o), .gain_o(gain_o),
    .result_valid_o(result_valid_o));

  adc_cycle_chk adc_cycle_chk_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .cs_n_i(link.cs_n),
    .sck_i(link.sck), .busy_i(link.busy), .sdo_i(link.sdo), .sdo_oe_i(link.sdo_oe),
    .sdo_line_i(link.sdo_line));

  initial clock_i = 1'b0;
  always #20 clock_i = ~clock_i;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // idle long enough after release that the first select high time is met
  task automatic do_reset();
    arst_n_i = 1'b0;
    repeat (5) @(negedge clock_i);
    arst_n_i = 1'b1;
    prior_done = 1'b0;
    repeat (20) @(negedge clock_i);
  endtask

  task automatic run(input logic lp, input logic byp, input logic [2:0] k);
    note_s      n;
    logic [2:0] kk;
    logic [31:0] r;
    int         i;
    for (i = 0; i < 400 && ready_o !== 1'b1; i++) @(negedge clock_i);
    kk = (k > 3'h6) ? 3'h6 : k;
    r = $random(seed);
    sample_i = r[13:0];
    channel_select_bits_i = r[16:14];
    gain_select_bits_i = r[19:17];
    low_power_select_i = lp;
    gain_bypass_i = byp;
    trailer_count_i = k;
    n.data = r[13:0];
    {n.ch, n.gain} = {r[16:14], r[19:17]} & ~(6'h3f >> kk);
    n.valid = lp | prior_done;
    prior_done = 1'b1;
    notes.push_back(n);
    // start held three cycles: only the first may be taken
    start_i = 1'b1;
    repeat (3) @(negedge clock_i);
    start_i = 1'b0;
    check("ready_low", 16'(ready_o), 16'h0000);
    for (i = 0; i < 100 && link.busy !== 1'b1; i++) @(negedge clock_i);
    // the converter must have latched its inputs by now
    r = $random(seed);
    sample_i = r[13:0];
    channel_select_bits_i = r[16:14];
    gain_select_bits_i = r[19:17];
    for (i = 0; i < 400 && notes.size() != 0; i++) @(negedge clock_i);
  endtask

  always @(negedge clock_i) begin
    if (conv_done_o === 1'b1) begin
      check("conv_done_busy", 16'(link.busy), 16'h0000);
      check("conv_done_oe", 16'(link.sdo_oe), 16'h0001);
    end
    if (result_valid_o === 1'b1) begin
      if (notes.size() == 0) begin
        check("extra_result", 16'h0001, 16'h0000);
      end else begin
        got = notes.pop_front();
        check("result", 16'(result_o), 16'(got.data));
        check("channel", 16'(channel_o), 16'(got.ch));
        check("gain", 16'(gain_o), 16'(got.gain));
        check("sample_valid", 16'(sample_valid_o), 16'(got.valid));
        if (low_power_select_i) begin
          check("acq", 16'(acquisition_cycles_o >= 16'h000d), 16'h0001);
        end
      end
    end
  end

  // about 25 samples of under 300 clocks each, so this leaves ample margin
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    end_sim();
  end

  initial begin
    seed = 32'hd6037e5a;
    err_total = 0;
    n_tests = 0;
    prior_done = 1'b0;
    start_i = 1'b0;
    low_power_select_i = 1'b1;
    gain_bypass_i = 1'b0;
    trailer_count_i = 3'h0;
    sample_i = 14'h0000;
    channel_select_bits_i = 3'h0;
    gain_select_bits_i = 3'h0;
    arst_n_i = 1'b0;
    do_reset();
    run(1'b1, 1'b0, 3'h6);
    for (m = 0; m < 20; m++) begin
      run(m[0], m[1], trl[m >> 2]);
    end
    // reset in mid-conversion must free the link at once
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    for (m = 0; m < 100 && link.busy !== 1'b1; m++) @(negedge clock_i);
    arst_n_i = 1'b0;
    #1;
    check("cs_idle", 16'(link.cs_n), 16'h0001);
    check("line_idle", 16'(link.sdo_line), 16'h0001);
    check("busy_idle", 16'(link.busy), 16'h0000);
    do_reset();
    run(1'b0, 1'b1, 3'h3);
    run(1'b0, 1'b0, 3'h2);
    check("notes_left", 16'(notes.size()), 16'h0000);
    end_sim();
  end
endmodule
